/* design/bgpio_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bgpio_pin_sync #(
  parameter int W = 48
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] pinIn,
  bgpio_sync_if.src syncOut
);
  logic [W-1:0] stage1, stage2, stage3, stable;
  logic [W-1:0] next_stable;

  always_comb begin
    next_stable = stable;
    for (int i = 0; i < W; i++) begin
      // second and third stages must agree before a change counts
      if (stage2[i] == stage3[i]) begin
        next_stable[i] = stage2[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
      stable <= '1;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      stable <= next_stable;
    end
  end

  assign syncOut.level = stable;
endmodule
`default_nettype wire

/* design/bgpio_pkg.sv */
// constants for the bidirectional port block
package bgpio_pkg;
  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 5;
  // register index = port * 4 + kind
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_DIR = 2'h1;
  localparam logic [1:0] KIND_PULL = 2'h2;
  localparam logic [1:0] KIND_WAKE = 2'h3;
  localparam logic [4:0] ADDR_WAKE_SELECT = 5'h03;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  // per-port implemented bit masks, largest variant
  localparam logic [47:0] PORT_MASKS = 48'h3F_FF_FF_FF_FF_FF;
endpackage

/* design/bgpio_ports.sv */
// bidirectional I/O port block on the data memory bus
// Behaviour
// RULE1: port reads are not latched; the live synchronised pin level is returned
// RULE2: output latch holds its value until that port data register is written
// RULE3: unimplemented bits read zero and ignore writes
// RULE4: pull-high bit per pin, 1 enables, resets to 0
// RULE5: pull-high applied only for input or open-drain output pins
// RULE6: falling edge on enabled first-port pin wakes the processor from halt
// RULE7: first port has eight wake select bits, 1 enables, reset 0
// RULE8: wake select effective only for input pins while sleeping or idle
// RULE9: direction bit 1 makes the pin a readable input
// RULE10: direction bit 0 makes a CMOS output driving the latch; changeable anytime
// RULE11: all port registers live in the data memory space
// RULE12: port count and widths are parameters per variant
// RULE13: data read of an output pin returns the latch value
// RULE14: direction bits reset to 1, all pins start as inputs
// RULE15: synchronised first-port inputs raise one wake request on falling edge
`timescale 1ns/1ps
`default_nettype none
module bgpio_ports
  import bgpio_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter logic [47:0] MASKS = PORT_MASKS // RULE12
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata,
  input wire logic sleepMode,
  input wire logic [PORTS*PORT_W-1:0] pinIn,
  input wire logic [PORTS*PORT_W-1:0] openDrain,
  output logic [PORTS*PORT_W-1:0] pinOut,
  output logic [PORTS*PORT_W-1:0] pinOe,
  output logic [PORTS*PORT_W-1:0] pullHighOn,
  output logic wakeReq
);
  localparam int W = PORTS * PORT_W;

  bgpio_sync_if #(.W(W)) syncBus ();

  // register state and its next values
  logic [W-1:0] dataLatch, dirBits, pullBits;
  logic [W-1:0] next_dataLatch, next_dirBits, next_pullBits;
  logic [PORT_W-1:0] wakeSel, next_wakeSel;

  // pin-side and read-side next values
  logic [W-1:0] next_pinOut, next_pinOe, next_pullHighOn;
  logic [7:0] next_memRdata;

  // address decode
  logic [W-1:0] implMask;
  logic [2:0] selPort;
  logic [1:0] selKind;
  logic portValid;
  logic wakeAddr;
  logic wakeWrEn;
  logic [PORTS-1:0] portHit;
  logic [PORTS-1:0] dataWrEn;
  logic [PORTS-1:0] dirWrEn;
  logic [PORTS-1:0] pullWrEn;

  // per-port views, unimplemented bits already cleared
  logic [PORT_W-1:0] portMask [PORTS];
  logic [PORT_W-1:0] dataView [PORTS];
  logic [PORT_W-1:0] dirView [PORTS];
  logic [PORT_W-1:0] pullView [PORTS];
  logic [PORT_W-1:0] selData, selDir, selPull;

  // per-pin configuration
  logic [W-1:0] liveLevel;
  logic [W-1:0] pinDrives;
  logic [W-1:0] pinPullAllowed;

  assign implMask = MASKS[W-1:0];
  assign selPort = memAddr[4:2];
  assign selKind = memAddr[1:0];
  assign portValid = (int'(selPort) < PORTS);
  // wake select exists for the first port only
  assign wakeAddr = (memAddr == ADDR_WAKE_SELECT);
  assign wakeWrEn = memWrite & wakeAddr; // RULE7
  assign liveLevel = syncBus.level;

  bgpio_pin_sync #(.W(W)) pinSync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pinIn(pinIn),
    .syncOut(syncBus.src)
  );

  bgpio_wake #(.W(PORT_W)) wakeDet (
    .sys_clk(sys_clk),
    .reset(reset),
    .level(syncBus.level[PORT_W-1:0]),
    .wakeSelect(wakeSel),
    .isInput(dirBits[PORT_W-1:0]),
    .sleepMode(sleepMode),
    .wakeReq(wakeReq)
  );

  // decode and read views, one set per port
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    localparam int LO = p * PORT_W;
    logic [PORT_W-1:0] live;
    logic [PORT_W-1:0] lat;
    logic [PORT_W-1:0] dir;

    assign live = liveLevel[LO +: PORT_W];
    assign lat = dataLatch[LO +: PORT_W];
    assign dir = dirBits[LO +: PORT_W];
    assign portMask[p] = implMask[LO +: PORT_W];
    assign portHit[p] = (selPort == 3'(p));

    assign dataWrEn[p] = memWrite & portHit[p] & (selKind == KIND_DATA); // RULE2 RULE11
    assign dirWrEn[p] = memWrite & portHit[p] & (selKind == KIND_DIR); // RULE10 RULE11
    assign pullWrEn[p] = memWrite & portHit[p] & (selKind == KIND_PULL); // RULE4 RULE11

    // inputs show the live level, outputs the latch, never a stored copy of the pin
    assign dataView[p] = ((dir & live) | (~dir & lat)) & portMask[p]; // RULE1 RULE9 RULE13 RULE3
    assign dirView[p] = dir & portMask[p]; // RULE3
    assign pullView[p] = pullBits[LO +: PORT_W] & portMask[p]; // RULE3
  end

  // one-hot pick across ports keeps the read path free of out-of-range slices
  always_comb begin
    selData = '0;
    selDir = '0;
    selPull = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (portHit[p]) begin
        selData = selData | dataView[p];
        selDir = selDir | dirView[p];
        selPull = selPull | pullView[p];
      end
    end
  end

  // register writes, one byte lane per port
  always_comb begin
    next_dataLatch = dataLatch;
    next_dirBits = dirBits;
    next_pullBits = pullBits;
    next_wakeSel = wakeSel;
    for (int p = 0; p < PORTS; p++) begin
      // unimplemented bits are cut here and never reach a register
      if (dataWrEn[p]) begin
        next_dataLatch[p*PORT_W +: PORT_W] = memWdata & portMask[p]; // RULE2 RULE3
      end
      if (dirWrEn[p]) begin
        next_dirBits[p*PORT_W +: PORT_W] = memWdata & portMask[p]; // RULE10 RULE3
      end
      if (pullWrEn[p]) begin
        next_pullBits[p*PORT_W +: PORT_W] = memWdata & portMask[p]; // RULE4 RULE3
      end
    end
    if (wakeWrEn) begin
      next_wakeSel = memWdata & portMask[0]; // RULE7
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dataLatch <= {PORTS{DATA_RESET}};
      dirBits <= {PORTS{DIR_RESET}}; // RULE14
      pullBits <= {PORTS{PULL_RESET}}; // RULE4
      wakeSel <= WAKE_RESET; // RULE7
    end else begin
      dataLatch <= next_dataLatch;
      dirBits <= next_dirBits & implMask;
      pullBits <= next_pullBits;
      wakeSel <= next_wakeSel;
    end
  end

  // read data stands until the next read
  always_comb begin
    next_memRdata = memRdata;
    if (memRead) begin
      next_memRdata = 8'h00;
      if (portValid) begin
        unique case (selKind)
          KIND_DATA: next_memRdata = selData; // RULE1 RULE13
          KIND_DIR: next_memRdata = selDir; // RULE9
          KIND_PULL: next_memRdata = selPull; // RULE4
          KIND_WAKE: next_memRdata = wakeAddr ? wakeSel : 8'h00; // RULE7 RULE3
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      memRdata <= 8'h00;
    end else begin
      memRdata <= next_memRdata;
    end
  end

  // one slice per pin
  for (genvar i = 0; i < W; i++) begin : g_pin
    // an open-drain pin only pulls low; a high latch releases it
    assign pinDrives[i] = implMask[i] & ~dirBits[i] & (~openDrain[i] | ~dataLatch[i]); // RULE10
    // pull-high only for inputs and open-drain outputs
    assign pinPullAllowed[i] = implMask[i] & (dirBits[i] | openDrain[i]); // RULE5
  end

  always_comb begin
    next_pinOut = dataLatch & implMask; // RULE10
    // enable is low while the pin is driven
    next_pinOe = ~pinDrives;
    next_pullHighOn = pinPullAllowed & pullBits; // RULE4 RULE5
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinOut <= '0;
      pinOe <= '1;
      pullHighOn <= '0;
    end else begin
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
      pullHighOn <= next_pullHighOn;
    end
  end
endmodule
`default_nettype wire

/* design/bgpio_sync_if.sv */
// carrier between the pin synchroniser and the core
`timescale 1ns/1ps
`default_nettype none
interface bgpio_sync_if #(parameter int W = 48);
  logic [W-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface
`default_nettype wire

/* design/bgpio_wake.sv */
// first-port falling-edge wake detector
`timescale 1ns/1ps
`default_nettype none
module bgpio_wake #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] wakeSelect,
  input wire logic [W-1:0] isInput,
  input wire logic sleepMode,
  output logic wakeReq
);
  logic [W-1:0] prevLevel;
  logic next_wakeReq;

  always_comb begin
    // sleep-gated, input-only, falling edge, any enabled pin
    next_wakeReq = sleepMode & |(prevLevel & ~level & wakeSelect & isInput); // RULE6 RULE8 RULE15
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prevLevel <= '1;
      wakeReq <= 1'b0;
    end else begin
      prevLevel <= level;
      wakeReq <= next_wakeReq;
    end
  end
endmodule
`default_nettype wire

/* verif/bgpio_pin_model.sv */
// switches and loads on the port pins
`timescale 1ns/1ps
`default_nettype none
module bgpio_pin_model (
  input wire logic sys_clk,
  input wire logic [47:0] pinOut,
  input wire logic [47:0] pinOe,
  input wire logic [47:0] pullHighOn,
  input wire logic [47:0] swEn,
  input wire logic [47:0] swVal,
  output logic [47:0] pinIn
);
  logic [47:0] drift = 48'h0;
  // a floating pin wanders, so it never looks like a held level
  always @(posedge sys_clk) drift <= ~drift;
  assign pinIn = (~pinOe & pinOut) | (pinOe & swEn & swVal) | (pinOe & ~swEn & (pullHighOn | drift));
endmodule
`default_nettype wire

/* verif/bgpio_ports_bench.sv */
// self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
module bgpio_ports_bench;
  import bgpio_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] memAddr = 5'h00;
  logic memWrite = 1'b0;
  logic memRead = 1'b0;
  logic [7:0] memWdata = 8'h00;
  logic sleepMode = 1'b0;
  logic [47:0] openDrain = 48'h0;
  logic [47:0] swEn = 48'h0;
  logic [47:0] swVal = 48'h0;
  wire logic [47:0] pinIn, pinOut, pinOe, pullHighOn;
  wire logic [7:0] memRdata;
  wire logic wakeReq;
  int err_total = 0;
  int checked = 0;
  int pulses = 0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wakeReq === 1'b1) pulses++;
  bgpio_ports bgpio_ports_i (.sys_clk(sys_clk), .reset(reset), .memAddr(memAddr), .memWrite(memWrite),
    .memRead(memRead), .memWdata(memWdata), .memRdata(memRdata), .sleepMode(sleepMode), .pinIn(pinIn),
    .openDrain(openDrain), .pinOut(pinOut), .pinOe(pinOe), .pullHighOn(pullHighOn), .wakeReq(wakeReq));
  bgpio_pin_model bgpio_pin_model_i (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe),
    .pullHighOn(pullHighOn), .swEn(swEn), .swVal(swVal), .pinIn(pinIn));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    memWrite <= 1'b1;
    memAddr <= a;
    memWdata <= d;
    @(posedge sys_clk);
    memWrite <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    memRead <= 1'b1;
    memAddr <= a;
    @(posedge sys_clk);
    memRead <= 1'b0;
    #1 chk(48'(memRdata), 48'(exp));
  endtask
  task automatic t_reset;
    chk(pinOe, 48'hFFFFFFFFFFFF);
    chk(pullHighOn | pinOut, 48'h0);
    rdc(5'h01, 8'hFF);
    rdc(5'h15, 8'h3F);
    rdc(5'h02, 8'h00);
    rdc(5'h03, 8'h00);
  endtask
  task automatic t_output;
    logic [7:0] m;
    for (int p = 0; p < NUM_PORTS; p++) begin
      m = PORT_MASKS[p*8+:8];
      wr(5'(p * 4 + 1), 8'h00);
      wr(5'(p * 4), 8'hA5);
      tick(2);
      chk(48'(pinOut[p*8+:8] & m), 48'(8'hA5 & m));
      chk(48'(pinOe[p*8+:8] & m), 48'h0);
      rdc(5'(p * 4), 8'hA5 & m);
    end
    wr(5'h14, 8'hFF);
    rdc(5'h14, 8'h3F);
    wr(5'h01, 8'hFF);
    swEn <= 48'hFF;
    swVal <= 48'h3C;
    tick(8);
    rdc(5'h00, 8'h3C);
    chk(48'(pinOut[7:0]), 48'hA5);
  endtask
  task automatic t_unmapped;
    wr(5'h07, 8'hFF);
    wr(5'h1C, 8'hFF);
    rdc(5'h07, 8'h00);
    rdc(5'h1C, 8'h00);
    rdc(5'h03, 8'h00);
  endtask
  task automatic t_pull;
    wr(5'h02, 8'hFF);
    tick(3);
    chk(48'(pullHighOn[7:0]), 48'hFF);
    wr(5'h01, 8'h0F);
    tick(3);
    chk(48'(pullHighOn[7:0]), 48'h0F);
    @(posedge sys_clk);
    openDrain <= 48'hF0;
    tick(3);
    chk(48'(pullHighOn[7:0]), 48'hFF);
    chk(48'(pinOe[7:0]), 48'hAF);
    @(posedge sys_clk);
    openDrain <= 48'h0;
    wr(5'h01, 8'hFF);
    wr(5'h02, 8'h00);
  endtask
  task automatic t_wake;
    swVal <= 48'hFF;
    sleepMode <= 1'b1;
    wr(5'h03, 8'h01);
    rdc(5'h03, 8'h01);
    tick(8);
    pulses = 0;
    @(posedge sys_clk);
    swVal <= 48'hFC;
    tick(12);
    chk(48'(pulses), 48'h1);
    @(posedge sys_clk);
    swVal <= 48'hFF;
    sleepMode <= 1'b0;
    tick(8);
    @(posedge sys_clk);
    swVal <= 48'hFE;
    tick(12);
    chk(48'(pulses), 48'h1);
    // a driven output falling while asleep must not wake
    @(posedge sys_clk);
    swVal <= 48'hFF;
    tick(8);
    wr(5'h01, 8'hFE);
    @(posedge sys_clk);
    sleepMode <= 1'b1;
    tick(8);
    wr(5'h00, 8'hA4);
    tick(12);
    chk(48'(pulses), 48'h1);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    t_reset;
    t_output;
    t_unmapped;
    t_pull;
    t_wake;
    tally_and_finish;
  end
  // the whole run takes well under a tenth of this
  initial begin
    #20000;
    err_total++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* verif/bgpio_ports_properties.sv */
// concurrent checks on the port block
`timescale 1ns/1ps
`default_nettype none
module bgpio_ports_properties
  import bgpio_pkg::*;
#(parameter int PORTS = NUM_PORTS) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  input wire logic sleepMode,
  input wire logic [PORTS*PORT_W-1:0] pinOut,
  input wire logic [PORTS*PORT_W-1:0] pinOe,
  input wire logic [PORTS*PORT_W-1:0] pullHighOn,
  input wire logic wakeReq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_reset_values: assert property ($fell(reset) |-> pinOe == '1 && pullHighOn == '0 && pinOut == '0)
    else $error("reset values");
  a_dir_to_oe: assert property (memWrite && memAddr == 5'h01 |-> ##2 pinOe[7:0] == $past(memWdata, 2))
    else $error("direction not on pins");
  a_latch_to_pin: assert property (memWrite && memAddr == 5'h00 |-> ##2 pinOut[7:0] == $past(memWdata, 2))
    else $error("latch not on pins");
  a_latch_holds: assert property ($changed(pinOut[7:0]) |-> $past(memWrite, 2) && $past(memAddr, 2) == 5'h00)
    else $error("latch moved");
  a_rdata_on_read: assert property ($changed(memRdata) |-> $past(memRead))
    else $error("read data moved");
  a_unmapped_zero: assert property (memRead &&
    (memAddr >= PORTS * 4 || (memAddr[1:0] == 2'h3 && memAddr != 5'h03)) |=> memRdata == 8'h00)
    else $error("unmapped read");
  a_upper_masked: assert property (memRead && memAddr[4:2] == 3'h5 |=> memRdata[7:6] == 2'h0)
    else $error("unimplemented bits");
  a_wake_single: assert property (wakeReq |=> !wakeReq)
    else $error("wake pulse long");
  a_wake_asleep: assert property (wakeReq |-> $past(sleepMode) || $past(sleepMode, 2))
    else $error("wake while awake");
endmodule
bind bgpio_ports bgpio_ports_properties #(.PORTS(PORTS)) props_i (.sys_clk(sys_clk), .reset(reset), .memAddr(memAddr),
  .memWrite(memWrite), .memRead(memRead), .memWdata(memWdata), .memRdata(memRdata), .sleepMode(sleepMode),
  .pinOut(pinOut), .pinOe(pinOe), .pullHighOn(pullHighOn), .wakeReq(wakeReq));
`default_nettype wire
